/* logic/arf_pkg.sv */
package arf_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int RES_W    = 10;
   localparam int SAMPLE_W = 12;
   localparam int AMP_W    = 18;
   localparam int CH_W     = 6;
   localparam int BYTE_W   = 8;

   // ---------------------------------------------------------------
   // codes and limits
   // ---------------------------------------------------------------
   localparam logic [RES_W-1:0]        CODE_ZERO    = 10'h000;
   localparam logic [RES_W-1:0]        CODE_MAX     = 10'h3ff;
   localparam logic [RES_W-1:0]        BIP_MIN_CODE = 10'h200;
   localparam logic [RES_W-1:0]        BIP_MAX_CODE = 10'h1ff;
   localparam logic signed [AMP_W-1:0] UNI_HIGH     = 18'sh003ff;
   localparam logic signed [AMP_W-1:0] BIP_HIGH     = 18'sh001ff;
   localparam logic signed [AMP_W-1:0] BIP_LOW      = -18'sh00200;
   localparam int                      SIGN_POS     = 9;
   localparam int                      LEFT_PAD     = 6;

   // ---------------------------------------------------------------
   // channel map
   // ---------------------------------------------------------------
   localparam logic [CH_W-1:0] TEMP_SENSOR_CH = 6'h3f;
   localparam logic [CH_W-1:0] DIFF_A_FIRST   = 6'h0b;
   localparam logic [CH_W-1:0] DIFF_A_LAST    = 6'h1d;
   localparam logic [CH_W-1:0] DIFF_B_FIRST   = 6'h20;
   localparam logic [CH_W-1:0] DIFF_B_LAST    = 6'h3d;

   // ---------------------------------------------------------------
   // gain and mode
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {GAIN_1X, GAIN_8X, GAIN_20X, GAIN_32X} arf_gain_e;
   localparam logic signed [AMP_W-1:0] GAIN1_VAL  = 18'sh00001;
   localparam logic signed [AMP_W-1:0] GAIN8_VAL  = 18'sh00008;
   localparam logic signed [AMP_W-1:0] GAIN20_VAL = 18'sh00014;
   localparam logic signed [AMP_W-1:0] GAIN32_VAL = 18'sh00020;

   typedef enum logic [1:0] {MODE_SINGLE, MODE_UNIPOLAR, MODE_BIPOLAR} arf_mode_e;

endpackage : arf_pkg

/* logic/arf_fmt_if.sv */
`timescale 1ns/10ps
interface arf_fmt_if;
   import arf_pkg::*;

   arf_mode_e                  mode;
   arf_gain_e                  gain;
   logic signed [SAMPLE_W-1:0] sample;
   logic [RES_W-1:0]           code;

   modport req (output mode, output gain, output sample, input code);
   modport fmt (input mode, input gain, input sample, output code);

endinterface : arf_fmt_if

/* logic/arf_formatter.sv */
`timescale 1ns/10ps
module arf_formatter
   import arf_pkg::*;
(
   // ---------------------------------------------------------------
   // request side
   // ---------------------------------------------------------------
   arf_fmt_if.fmt fmt
);

   logic signed [AMP_W-1:0] mult;
   logic signed [AMP_W-1:0] amp;
   logic signed [AMP_W-1:0] half;

   always_comb begin
      case (fmt.gain) // see RULE4
         GAIN_8X:  mult = GAIN8_VAL;
         GAIN_20X: mult = GAIN20_VAL;
         GAIN_32X: mult = GAIN32_VAL;
         default:  mult = GAIN1_VAL;
      endcase
      // 18 bits hold 2047 * 32 without overflow
      amp  = AMP_W'(fmt.sample) * mult;
      half = amp >>> 1;
      case (fmt.mode)
         MODE_BIPOLAR: begin // see RULE6
            if (half < BIP_LOW) begin
               fmt.code = BIP_MIN_CODE;
            end else if (half > BIP_HIGH) begin
               fmt.code = BIP_MAX_CODE;
            end else begin
               fmt.code = half[RES_W-1:0]; // see RULE7
            end
         end
         default: begin // see RULE2 see RULE3
            if (amp < 0) begin
               fmt.code = CODE_ZERO;
            end else if (amp > UNI_HIGH) begin
               fmt.code = CODE_MAX;
            end else begin
               fmt.code = amp[RES_W-1:0];
            end
         end
      endcase
   end

endmodule : arf_formatter

/* logic/arf_result.sv */
// Behaviour
// RULE1: result readable once done flag is high
// RULE2: single-ended code unsigned, 0 to 0x3ff
// RULE3: unipolar code clamps negative difference to zero
// RULE4: differential gain one, eight, twenty, thirty-two
// RULE5: unipolar default, bipolar only when selected
// RULE6: bipolar two's complement 0x200 to 0x1ff
// RULE7: sign in top bit above nine bits
// RULE8: channel 111111 enables temperature sensor
// RULE9: software selects 1.1V reference for temperature
// RULE10: software uses single conversion for temperature
// RULE11: digital outputs stay quiet during conversion
// RULE12: noise-reduction sleep advised for accurate reads
// RULE13: high byte shifted eight, or low byte
// RULE14: result and done flag written together
// RULE15: left-adjust selects justification, takes effect immediately
// RULE16: result held until next conversion completes
`timescale 1ns/10ps
module arf_result
   import arf_pkg::*;
(
   // ---------------------------------------------------------------
   // clock and reset
   // ---------------------------------------------------------------
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // ---------------------------------------------------------------
   // converter core
   // ---------------------------------------------------------------
   input  wire logic                       conv_done_i,
   input  wire logic signed [SAMPLE_W-1:0] conv_sample_i,
   // ---------------------------------------------------------------
   // control
   // ---------------------------------------------------------------
   input  wire logic [CH_W-1:0]            channel_select_field_i,
   input  wire logic                       bipolar_select_i,
   input  wire logic                       left_adjust_select_i,
   input  wire logic [1:0]                 gain_select_i,
   input  wire logic                       done_clear_i,
   // ---------------------------------------------------------------
   // status and result
   // ---------------------------------------------------------------
   output logic [BYTE_W-1:0]               result_high_byte_o,
   output logic [BYTE_W-1:0]               result_low_byte_o,
   output logic                            conversion_done_flag_o,
   output logic                            result_sign_bit_o,
   output logic                            temp_sensor_enable_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [RES_W-1:0]  result;
      logic [BYTE_W-1:0] high;
      logic [BYTE_W-1:0] low;
      logic              done;
      logic              sign;
      logic              temp_en;
   } arf_state_s;

   arf_state_s state_reg;
   arf_state_s state_next;
   logic       is_diff;
   arf_fmt_if  fmt_bus ();

   // ---------------------------------------------------------------
   // mode and gain decode
   // ---------------------------------------------------------------
   always_comb begin
      is_diff = ((channel_select_field_i >= DIFF_A_FIRST) &&
                 (channel_select_field_i <= DIFF_A_LAST)) ||
                ((channel_select_field_i >= DIFF_B_FIRST) &&
                 (channel_select_field_i <= DIFF_B_LAST));
      if (!is_diff) begin
         fmt_bus.mode = MODE_SINGLE;
      end else if (bipolar_select_i) begin
         fmt_bus.mode = MODE_BIPOLAR; // see RULE5
      end else begin
         fmt_bus.mode = MODE_UNIPOLAR; // see RULE5
      end
      // single-ended inputs bypass the gain stage
      fmt_bus.gain   = is_diff ? arf_gain_e'(gain_select_i) : GAIN_1X; // see RULE4
      fmt_bus.sample = conv_sample_i;
   end

   arf_formatter u_formatter (
      .fmt (fmt_bus.fmt)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (conv_done_i) begin
         state_next.result = fmt_bus.code; // see RULE14 see RULE16
         state_next.sign   = fmt_bus.code[SIGN_POS]; // see RULE7
      end
      // a new completion wins over a clear in the same cycle
      state_next.done = conv_done_i | (state_reg.done & ~done_clear_i); // see RULE14 see RULE1
      // bytes follow the adjust bit every cycle, not only on completion
      if (left_adjust_select_i) begin // see RULE15
         state_next.high = state_next.result[RES_W-1:RES_W-BYTE_W];
         state_next.low  = {state_next.result[RES_W-BYTE_W-1:0], {LEFT_PAD{1'b0}}};
      end else begin // see RULE13
         state_next.high = BYTE_W'(state_next.result[RES_W-1:BYTE_W]);
         state_next.low  = state_next.result[BYTE_W-1:0];
      end
      state_next.temp_en = (channel_select_field_i == TEMP_SENSOR_CH); // see RULE8
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign result_high_byte_o     = state_reg.high;
   assign result_low_byte_o      = state_reg.low;
   assign conversion_done_flag_o = state_reg.done;
   assign result_sign_bit_o      = state_reg.sign;
   assign temp_sensor_enable_o   = state_reg.temp_en;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_complete;
      conv_done_i ##1 conversion_done_flag_o;
   endsequence

   sequence s_completion_cause;
      conv_done_i && !rst_i;
   endsequence

   property p_result_with_flag;
      s_completion_cause |=> (state_reg.result == $past(fmt_bus.code))
                             && conversion_done_flag_o;
   endproperty

   AST_DONE_WITH_RESULT: assert property (p_result_with_flag) // see RULE14
      else $error("result and done flag not written together");

   AST_FLAG_HOLDS: assert property (s_complete ##0 !conv_done_i && !done_clear_i // see RULE1
                                    |=> conversion_done_flag_o)
      else $error("done flag dropped without clear");

   AST_RESULT_HELD: assert property (!conv_done_i |=> $stable(state_reg.result)) // see RULE16
      else $error("result changed without completion");

   AST_SINGLE_FULL: assert property (conv_done_i && !is_diff // see RULE2
                                     && conv_sample_i >= 12'sh400
                                     |=> state_reg.result == CODE_MAX)
      else $error("single-ended overrange not 0x3ff");

   AST_UNIPOLAR_ZERO: assert property (conv_done_i && is_diff && !bipolar_select_i // see RULE3
                                       && conv_sample_i < 0
                                       |=> state_reg.result == CODE_ZERO)
      else $error("unipolar negative difference not zero");

   AST_GAIN_EIGHT: assert property (conv_done_i && is_diff && !bipolar_select_i // see RULE4
                                    && gain_select_i == 2'h1 && conv_sample_i == 12'sh010
                                    |=> state_reg.result == 10'h080)
      else $error("gain of eight misapplied");

   AST_BIPOLAR_MIN: assert property (conv_done_i && is_diff && bipolar_select_i // see RULE6
                                     && conv_sample_i <= -12'sh400
                                     |=> state_reg.result == BIP_MIN_CODE)
      else $error("bipolar underrange not 0x200");

   AST_BIPOLAR_MAX: assert property (conv_done_i && is_diff && bipolar_select_i // see RULE6
                                     && conv_sample_i >= 12'sh400
                                     |=> state_reg.result == BIP_MAX_CODE)
      else $error("bipolar overrange not 0x1ff");

   AST_BIPOLAR_HALF: assert property (conv_done_i && is_diff && bipolar_select_i // see RULE5
                                      && gain_select_i == 2'h0 && conv_sample_i == 12'sh100
                                      |=> state_reg.result == 10'h080)
      else $error("bipolar scale not halved");

   AST_SIGN_BIT: assert property (conv_done_i && is_diff && bipolar_select_i // see RULE7
                                  && conv_sample_i < 0
                                  |=> result_sign_bit_o
                                      && result_high_byte_o[BYTE_W-1:0] != 8'h00)
      else $error("negative bipolar result lacks sign");

   AST_RIGHT_SPLIT: assert property ($past(!left_adjust_select_i) |-> // see RULE13
                                     {result_high_byte_o, result_low_byte_o}
                                     == 16'(state_reg.result))
      else $error("right-adjusted bytes do not rebuild result");

   AST_LEFT_SPLIT: assert property ($rose(left_adjust_select_i) |=> // see RULE15
                                    {result_high_byte_o, result_low_byte_o}
                                    == {state_reg.result, 6'h00})
      else $error("left adjust not applied at once");

   AST_TEMP_ENABLE: assert property (channel_select_field_i == TEMP_SENSOR_CH // see RULE8
                                     |=> temp_sensor_enable_o)
      else $error("temperature sensor not enabled");

   AST_TEMP_DISABLE: assert property (channel_select_field_i != TEMP_SENSOR_CH // see RULE8
                                      |=> !temp_sensor_enable_o)
      else $error("temperature sensor enabled on other channel");

   // a clear only counts when no completion lands in the same cycle
   sequence s_clear_only;
      done_clear_i && !conv_done_i;
   endsequence

   AST_CLEAR_DROPS: assert property (s_clear_only |=> !conversion_done_flag_o) // see RULE1
      else $error("done flag not cleared");

   AST_SET_OVER_CLEAR: assert property (conv_done_i && done_clear_i // see RULE14
                                        |=> conversion_done_flag_o)
      else $error("clear beat a completion in the same cycle");

endmodule : arf_result

/* verif/arf_result_tb.sv */
`timescale 1ns/10ps
module arf_result_tb;
   import arf_pkg::*;

   // ---------------------------------------------------------------
   // stimulus and dut
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [BYTE_W-1:0] hi;
      logic [BYTE_W-1:0] lo;
      logic              flag;
      logic              sign;
      logic              temp;
   } arf_note_s;

   logic                       clk_i;
   logic                       rst_i;
   logic                       conv_done_i;
   logic signed [SAMPLE_W-1:0] conv_sample_i;
   logic [CH_W-1:0]            channel_select_field_i;
   logic                       bipolar_select_i;
   logic                       left_adjust_select_i;
   logic [1:0]                 gain_select_i;
   logic                       done_clear_i;
   logic [BYTE_W-1:0]          result_high_byte_o;
   logic [BYTE_W-1:0]          result_low_byte_o;
   logic                       conversion_done_flag_o;
   logic                       result_sign_bit_o;
   logic                       temp_sensor_enable_o;
   arf_note_s                  notes[$];
   logic                       exp_now;
   logic [RES_W-1:0]           m_res;
   logic                       m_flag;
   logic [31:0]                seed;
   int                         n_errors;
   int                         cmp_count;

   arf_result dut (
      .clk_i                  (clk_i),
      .rst_i                  (rst_i),
      .conv_done_i            (conv_done_i),
      .conv_sample_i          (conv_sample_i),
      .channel_select_field_i (channel_select_field_i),
      .bipolar_select_i       (bipolar_select_i),
      .left_adjust_select_i   (left_adjust_select_i),
      .gain_select_i          (gain_select_i),
      .done_clear_i           (done_clear_i),
      .result_high_byte_o     (result_high_byte_o),
      .result_low_byte_o      (result_low_byte_o),
      .conversion_done_flag_o (conversion_done_flag_o),
      .result_sign_bit_o      (result_sign_bit_o),
      .temp_sensor_enable_o   (temp_sensor_enable_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // expected code worked out independently of the design
   function automatic logic [RES_W-1:0] exp_code(input logic signed [SAMPLE_W-1:0] s,
                                                 input logic [CH_W-1:0] ch,
                                                 input logic bip, input logic [1:0] g);
      int   a;
      int   gv;
      logic diff;
      diff = (ch >= 6'h0b && ch <= 6'h1d) || (ch >= 6'h20 && ch <= 6'h3d);
      gv = !diff ? 1 : (g == 2'h0) ? 1 : (g == 2'h1) ? 8 : (g == 2'h2) ? 20 : 32;
      a = int'(s) * gv;
      if (diff && bip) begin
         a = a >>> 1;
         a = (a < -512) ? -512 : (a > 511) ? 511 : a;
      end else begin
         a = (a < 0) ? 0 : (a > 1023) ? 1023 : a;
      end
      return a[RES_W-1:0];
   endfunction : exp_code

   task automatic chk(input string nm, input logic [7:0] exp_v, input logic [7:0] got);
      cmp_count++;
      if (got !== exp_v) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp_v, got);
      end
   endtask : chk

   // one cycle of stimulus plus the note of what must show after the edge
   task automatic step(input logic rst, input logic cd, input logic clr, input logic adj,
                       input logic [CH_W-1:0] ch, input logic bip, input logic [1:0] g,
                       input logic [SAMPLE_W-1:0] smp);
      arf_note_s n;
      @(negedge clk_i);
      rst_i = rst;
      conv_done_i = cd;
      done_clear_i = clr;
      left_adjust_select_i = adj;
      channel_select_field_i = ch;
      bipolar_select_i = bip;
      gain_select_i = g;
      conv_sample_i = smp;
      if (rst) begin
         m_res = 10'h000;
         m_flag = 1'b0;
      end else if (cd) begin
         m_res = exp_code(smp, ch, bip, g);
         m_flag = 1'b1;
      end else if (clr) begin
         m_flag = 1'b0;
      end
      n.hi = adj ? m_res[9:2] : {6'h00, m_res[9:8]};
      n.lo = adj ? {m_res[1:0], 6'h00} : m_res[7:0];
      n.flag = m_flag;
      n.sign = m_res[9];
      n.temp = !rst && (ch == 6'h3f);
      notes.push_back(n);
      exp_now = 1'b1;
   endtask : step

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // ---------------------------------------------------------------
   // monitor: checks just after each edge that carries a note
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin : mon
      arf_note_s e;
      logic      due;
      due = exp_now;
      #2;
      if (due) begin
         if (notes.size() == 0) begin
            n_errors++;
            $display("MISMATCH note_queue expected entry seen empty");
         end else begin
            e = notes.pop_front();
            chk("high_byte", e.hi, result_high_byte_o);
            chk("low_byte", e.lo, result_low_byte_o);
            chk("done_flag", {7'h00, e.flag}, {7'h00, conversion_done_flag_o});
            chk("sign_bit", {7'h00, e.sign}, {7'h00, result_sign_bit_o});
            chk("temp_enable", {7'h00, e.temp}, {7'h00, temp_sensor_enable_o});
         end
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   logic [SAMPLE_W-1:0] corner [10] = '{12'h000, 12'h3ff, 12'h400, 12'hfff,
                                         12'h800, 12'h7ff, 12'h1ff, 12'h200, 12'h010, 12'h100};
   logic [CH_W-1:0]     chans  [3] = '{6'h3f, 6'h0b, 6'h3d};

   initial begin
      rst_i = 1'b1; conv_done_i = 1'b0; done_clear_i = 1'b0; left_adjust_select_i = 1'b0;
      channel_select_field_i = 6'h00; bipolar_select_i = 1'b0; gain_select_i = 2'h0;
      conv_sample_i = 12'h000; exp_now = 1'b0; m_res = 10'h000; m_flag = 1'b0;
      n_errors = 0; cmp_count = 0; seed = 32'd82375;
      repeat (2) step(1'b1, 1'b0, 1'b0, 1'b0, 6'h00, 1'b0, 2'h0, 12'h000);
      $display("test reset done");
      // back to back conversions over every mode, gain and boundary sample
      for (int i = 0; i < 10; i++) begin
         for (int g = 0; g < 4; g++) begin
            for (int m = 0; m < 4; m++) begin
               step(1'b0, 1'b1, 1'b0, m[0] ^ g[0], chans[(m == 3) ? 1 : m], m[0] & m[1],
                    g[1:0], corner[i]);
            end
         end
      end
      $display("test directed_coding done");
      // temperature read: reference and sleep mode live outside this block, so the bench
      // holds the done clear for three cycles, then keeps every input quiet around one single conversion on the sensor channel
      repeat (3) step(1'b0, 1'b0, 1'b1, 1'b0, 6'h3f, 1'b0, 2'h0, 12'h000);
      step(1'b0, 1'b1, 1'b0, 1'b0, 6'h3f, 1'b0, 2'h0, 12'h12c);
      step(1'b0, 1'b0, 1'b0, 1'b0, 6'h3f, 1'b0, 2'h0, 12'h000);
      $display("test temp_single done");
      // random mix of idle cycles, clears, set-over-clear and a mid-run reset
      for (int i = 0; i < 300; i++) begin
         for (int k = 0; k < 32; k++) seed = lfsr_next(seed);
         step(i == 150, seed[0], seed[1] & seed[2], seed[3],
              (seed[10] & seed[11]) ? 6'h3f : seed[9:4], seed[24], seed[26:25], seed[23:12]);
      end
      $display("test random_mix done");
      @(negedge clk_i);
      exp_now = 1'b0;
      @(posedge clk_i);
      #5;
      report_and_stop();
   end

   // hang guard, far beyond the length of the run
   initial begin
      #100000;
      n_errors++;
      $display("MISMATCH watchdog expected finish seen timeout");
      report_and_stop();
   end

endmodule : arf_result_tb
